// File: bank_if.sv
/*
 * Carrier between the register bank top and its two leaf modules.
 * Assumes all three sit on the same clock.
 */
`timescale 1ns/10ps
interface bank_if;
    logic [3:0]  mask_set;    // Bits to set in the receive mask
    logic [3:0]  mask_clr;    // Bits to clear in the receive mask
    logic [3:0]  mask;        // Current receive mask
    logic [12:0] bw_init;     // Initial bandwidth field
    logic [31:0] hi_init;     // Initial channels high field
    logic [31:0] lo_init;     // Initial channels low field
    logic        load;        // Copy initial values into the CSRs

    modport mask_side (input mask_set, mask_clr, output mask);
    modport load_side (input bw_init, hi_init, lo_init, load);
    modport ctrl      (output mask_set, mask_clr, bw_init, hi_init, lo_init, load,
                       input mask);
endinterface

// File: bus_mgmt_loader.sv
/*
 * Bus management CSR copies: bandwidth available and channels available
 * high and low, loaded from the initial value fields on any reset event.
 * Assumes load is a same-clock level that stands while the reset lasts.
 */
`timescale 1ns/10ps
module bus_mgmt_loader
    import iso_bank_pkg::*;
(
    input  wire logic        clk,          // 25 MHz clock
    input  wire logic        rstn,         // Synchronous reset, active low
    input  wire logic        ce,           // Clock enable
    bank_if.load_side        b,            // Initial values and load
    output logic [12:0]      bw_avail,     // BANDWIDTH_AVAILABLE copy
    output logic [31:0]      chan_hi,      // CHANNELS_AVAILABLE_HI copy
    output logic [31:0]      chan_lo       // CHANNELS_AVAILABLE_LO copy
);
    logic [12:0] bw_reg, bw_next;
    logic [31:0] hi_reg, hi_next;
    logic [31:0] lo_reg, lo_next;

    always_comb begin
        bw_next = b.load ? b.bw_init : bw_reg;
        hi_next = b.load ? b.hi_init : hi_reg;
        lo_next = b.load ? b.lo_init : lo_reg;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            bw_reg <= RST_INIT_BW;
            hi_reg <= RST_INIT_CHAN;
            lo_reg <= RST_INIT_CHAN;
        end else if (ce) begin
            bw_reg <= bw_next;
            hi_reg <= hi_next;
            lo_reg <= lo_next;
        end
    end

    assign bw_avail = bw_reg;
    assign chan_hi  = hi_reg;
    assign chan_lo  = lo_reg;
endmodule

// File: iso_bank_pkg.sv
/*
 * Shared constants for the isochronous receive mask and the bus management
 * initial value bank: register offsets, field widths and reset values.
 * Assumes an 8-bit byte address on the register port and 32-bit data.
 */
package iso_bank_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [7:0] OFF_RX_EVENT_CLEAR = 8'hA4;
    localparam logic [7:0] OFF_RX_MASK_SET    = 8'hA8;
    localparam logic [7:0] OFF_RX_MASK_CLEAR  = 8'hAC;
    localparam logic [7:0] OFF_INIT_BW        = 8'hB0;
    localparam logic [7:0] OFF_INIT_CHAN_HI   = 8'hB4;
    localparam logic [7:0] OFF_INIT_CHAN_LO   = 8'hB8;

    // Field layout
    localparam int RX_CTX_N = 4;
    localparam int BW_W     = 13;
    localparam int CHAN_W   = 32;

    // Reset values
    localparam logic [3:0]  RST_RX_MASK   = 4'h0;
    localparam logic [12:0] RST_INIT_BW   = 13'h1333;
    localparam logic [31:0] RST_INIT_CHAN = 32'hFFFF_FFFF;
    localparam logic [31:0] RDATA_ZERO    = 32'h0000_0000;

    // Pin synchroniser depth
    localparam int SYNC_STAGES = 2;

endpackage

// File: iso_rx_mask_and_bus_mgmt_init_regs.sv
/*
 * Register slice: isochronous receive interrupt mask (set/clear pair),
 * masked read of the receive events, and the three bus management
 * initial value registers with their copy into the CSRs.
 * Assumes the receive event bits come from same-clock logic, the global
 * and host bus reset inputs are asynchronous pins, and the 1394 bus reset
 * and software reset are same-clock levels.
 */
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////

// Notes on behaviour
// - Each receive context has a mask bit that decides whether it feeds the summary irq.
// - Reading the mask at its set or its clear address returns the mask unchanged.
// - Mask bit n sits at the same position as receive event bit n and governs context n.
// - The mask has a set and a clear address; bits 3..0 are live, bits 31..4 read zero.
// - The 13-bit initial bandwidth is writable, presets to 1333h, survives a bus reset.
// - Bits 31..13 of the initial bandwidth register ignore writes and read zero.
// - Global, host bus or 1394 bus reset copies the initial bandwidth into its CSR.
// - Initial channels high is writable, presets to all ones, is copied on a global, host bus or 1394 bus reset.
// - Initial channels low is writable, presets to all ones, is copied on a global, host bus or 1394 bus reset.
// - Reading the event clear address returns the event bits ANDed with the mask.
// - A one written at set sets the bit, at clear clears it; a zero changes nothing.
module iso_rx_mask_and_bus_mgmt_init_regs
    import iso_bank_pkg::*;
(
    input  wire logic        clk,                      // 25 MHz clock
    input  wire logic        rstn,                     // Synchronous reset, active low
    input  wire logic        ce,                       // Clock enable, freezes state when low
    input  wire logic [7:0]  addr,                     // Register byte address
    input  wire logic [31:0] wdata,                    // Write data
    input  wire logic        wr,                       // Write strobe
    input  wire logic        rd,                       // Read strobe
    output logic      [31:0] rdata,                    // Read data, cycle after rd
    input  wire logic [3:0]  rx_event,                 // Receive event bits per context
    input  wire logic        soft_reset,               // Software reset level
    input  wire logic        global_reset_input,       // Global reset pin
    input  wire logic        host_bus_reset_input,     // Host bus reset pin
    input  wire logic        bus_reset_1394,           // 1394 bus reset level
    output logic             iso_receive_summary_irq,  // Summary irq source
    output logic      [12:0] bandwidth_available,      // BANDWIDTH_AVAILABLE CSR
    output logic      [31:0] channels_available_hi,    // CHANNELS_AVAILABLE_HI CSR
    output logic      [31:0] channels_available_lo     // CHANNELS_AVAILABLE_LO CSR
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    function automatic logic [31:0] widen4(input logic [3:0] v);
        widen4 = {28'h000_0000, v};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers for the two reset pins

    logic [1:0] global_reset_input_sync_reg;
    logic [1:0] global_reset_input_sync_next;
    logic [1:0] host_bus_reset_input_sync_reg;
    logic [1:0] host_bus_reset_input_sync_next;

    always_comb begin
        global_reset_input_sync_next = {global_reset_input_sync_reg[0], global_reset_input};
        host_bus_reset_input_sync_next = {host_bus_reset_input_sync_reg[0], host_bus_reset_input};
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            global_reset_input_sync_reg <= 2'h0;
            host_bus_reset_input_sync_reg <= 2'h0;
        end else if (ce) begin
            global_reset_input_sync_reg <= global_reset_input_sync_next;
            host_bus_reset_input_sync_reg <= host_bus_reset_input_sync_next;
        end
    end

    logic any_reset_event;
    assign any_reset_event = global_reset_input_sync_reg[1] | host_bus_reset_input_sync_reg[1] | bus_reset_1394;

    ////////////////////////////////////////////////////////////////////////////
    // Write decode

    logic wr_mask_set;
    logic wr_mask_clr;
    logic wr_bw;
    logic wr_hi;
    logic wr_lo;

    assign wr_mask_set = wr & hit(addr, OFF_RX_MASK_SET);
    assign wr_mask_clr = wr & hit(addr, OFF_RX_MASK_CLEAR);
    assign wr_bw       = wr & hit(addr, OFF_INIT_BW);
    assign wr_hi       = wr & hit(addr, OFF_INIT_CHAN_HI);
    assign wr_lo       = wr & hit(addr, OFF_INIT_CHAN_LO);

    ////////////////////////////////////////////////////////////////////////////
    // Receive mask

    bank_if b ();

    assign b.mask_set = wr_mask_set ? wdata[3:0] : 4'h0;
    assign b.mask_clr = wr_mask_clr ? wdata[3:0] : 4'h0;

    rx_mask_bank u_mask (
        .clk  (clk),
        .rstn (rstn),
        .ce   (ce),
        .b    (b.mask_side)
    );

    assign iso_receive_summary_irq = |(rx_event & b.mask);

    ////////////////////////////////////////////////////////////////////////////
    // Initial value registers

    logic [12:0] init_bw_reg;
    logic [12:0] init_bw_next;
    logic [31:0] init_hi_reg;
    logic [31:0] init_hi_next;
    logic [31:0] init_lo_reg;
    logic [31:0] init_lo_next;

    always_comb begin
        init_bw_next = init_bw_reg;
        init_hi_next = init_hi_reg;
        init_lo_next = init_lo_reg;
        if (soft_reset) begin
            init_bw_next = RST_INIT_BW;
            init_hi_next = RST_INIT_CHAN;
            init_lo_next = RST_INIT_CHAN;
        end else begin
            if (wr_bw) begin
                init_bw_next = wdata[12:0];
            end
            if (wr_hi) begin
                init_hi_next = wdata;
            end
            if (wr_lo) begin
                init_lo_next = wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            init_bw_reg <= RST_INIT_BW;
            init_hi_reg <= RST_INIT_CHAN;
            init_lo_reg <= RST_INIT_CHAN;
        end else if (ce) begin
            init_bw_reg <= init_bw_next;
            init_hi_reg <= init_hi_next;
            init_lo_reg <= init_lo_next;
        end
    end

    assign b.bw_init = init_bw_reg;
    assign b.hi_init = init_hi_reg;
    assign b.lo_init = init_lo_reg;
    assign b.load    = any_reset_event;

    bus_mgmt_loader u_loader (
        .clk      (clk),
        .rstn     (rstn),
        .ce       (ce),
        .b        (b.load_side),
        .bw_avail (bandwidth_available),
        .chan_hi  (channels_available_hi),
        .chan_lo  (channels_available_lo)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    always_comb begin
        rdata_next = RDATA_ZERO;
        if (rd) begin
            case (addr)
                OFF_RX_EVENT_CLEAR: rdata_next = widen4(rx_event & b.mask);
                OFF_RX_MASK_SET:    rdata_next = widen4(b.mask);
                OFF_RX_MASK_CLEAR:  rdata_next = widen4(b.mask);
                OFF_INIT_BW:        rdata_next = {19'h0_0000, init_bw_reg};
                OFF_INIT_CHAN_HI:   rdata_next = init_hi_reg;
                OFF_INIT_CHAN_LO:   rdata_next = init_lo_reg;
                default:            rdata_next = RDATA_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdata_reg <= RDATA_ZERO;
        end else if (ce) begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_mask_set_wr;
        ce && wr && addr == OFF_RX_MASK_SET;
    endsequence

    sequence s_mask_clr_wr;
        ce && wr && addr == OFF_RX_MASK_CLEAR;
    endsequence

    sequence s_mask_rd;
        ce && rd && (addr == OFF_RX_MASK_SET || addr == OFF_RX_MASK_CLEAR);
    endsequence

    chk_mask_set_bits: assert property (
        @(posedge clk) disable iff (!rstn)
        s_mask_set_wr |=> ((b.mask & $past(wdata[3:0])) == $past(wdata[3:0]))
            && ((b.mask & ~$past(wdata[3:0])) == ($past(b.mask) & ~$past(wdata[3:0]))))
        else $error("mask set write did not set exactly the written ones");

    chk_mask_clear_bits: assert property (
        @(posedge clk) disable iff (!rstn)
        s_mask_clr_wr |=> ((b.mask & $past(wdata[3:0])) == 4'h0)
            && (b.mask == ($past(b.mask) & ~$past(wdata[3:0]))))
        else $error("mask clear write did not clear exactly the written ones");

    chk_mask_read_same: assert property (
        @(posedge clk) disable iff (!rstn)
        s_mask_rd |=> rdata == widen4($past(b.mask)))
        else $error("mask read returned wrong value");

    chk_event_masked_rd: assert property (
        @(posedge clk) disable iff (!rstn)
        (ce && rd && addr == OFF_RX_EVENT_CLEAR)
            |=> rdata == widen4($past(rx_event) & $past(b.mask)))
        else $error("event clear read is not events ANDed with mask");

    chk_irq_gating: assert property (
        @(posedge clk) disable iff (!rstn)
        iso_receive_summary_irq == ((rx_event & b.mask) != 4'h0))
        else $error("summary irq disagrees with events and mask");

    chk_mask_upper_zero: assert property (
        @(posedge clk) disable iff (!rstn)
        s_mask_rd |=> rdata[31:4] == 28'h000_0000)
        else $error("mask read upper bits not zero");

    chk_bw_upper_zero: assert property (
        @(posedge clk) disable iff (!rstn)
        (ce && rd && addr == OFF_INIT_BW) |=> rdata[31:13] == 19'h0_0000
            && rdata[12:0] == $past(init_bw_reg))
        else $error("initial bandwidth read wrong");

    chk_bw_copy_load: assert property (
        @(posedge clk) disable iff (!rstn)
        (ce && b.load) |=> bandwidth_available == $past(init_bw_reg))
        else $error("bandwidth CSR not loaded from initial value");

    chk_hi_copy_load: assert property (
        @(posedge clk) disable iff (!rstn)
        (ce && b.load) |=> channels_available_hi == $past(init_hi_reg))
        else $error("channels high CSR not loaded");

    chk_lo_copy_load: assert property (
        @(posedge clk) disable iff (!rstn)
        (ce && b.load) |=> channels_available_lo == $past(init_lo_reg))
        else $error("channels low CSR not loaded");

    chk_soft_preset: assert property (
        @(posedge clk) disable iff (!rstn)
        (ce && soft_reset) |=> init_bw_reg == RST_INIT_BW
            && init_hi_reg == RST_INIT_CHAN && init_lo_reg == RST_INIT_CHAN)
        else $error("software reset did not preset initial values");

    chk_bus_reset_keep: assert property (
        @(posedge clk) disable iff (!rstn)
        (ce && bus_reset_1394 && !soft_reset && !wr) |=> $stable(init_bw_reg)
            && $stable(init_hi_reg) && $stable(init_lo_reg))
        else $error("bus reset disturbed initial values");

    chk_pin_to_load: assert property (
        @(posedge clk) disable iff (!rstn)
        (ce && global_reset_input) ##1 ce [*2] |-> b.load)
        else $error("global reset pin did not reach load after sync");

    chk_host_pin_load: assert property (
        @(posedge clk) disable iff (!rstn)
        (ce && host_bus_reset_input) ##1 ce [*2] |-> b.load)
        else $error("host bus reset pin did not reach load after sync");

    chk_rdata_idle_zero: assert property (
        @(posedge clk) disable iff (!rstn)
        (ce && !rd) |=> rdata == RDATA_ZERO)
        else $error("read data did not return to zero after its cycle");

    chk_mask_hold: assert property (
        @(posedge clk) disable iff (!rstn)
        !(ce && wr && (addr == OFF_RX_MASK_SET || addr == OFF_RX_MASK_CLEAR))
            |=> $stable(b.mask))
        else $error("mask changed without a set or clear write");

    chk_csr_hold: assert property (
        @(posedge clk) disable iff (!rstn)
        !(ce && b.load) |=> $stable(bandwidth_available)
            && $stable(channels_available_hi) && $stable(channels_available_lo))
        else $error("bus management CSRs changed without a load");

    // Field writes that no software reset overrides
    sequence s_bw_wr;
        ce && wr && !soft_reset && addr == OFF_INIT_BW;
    endsequence

    sequence s_hi_wr;
        ce && wr && !soft_reset && addr == OFF_INIT_CHAN_HI;
    endsequence

    sequence s_lo_wr;
        ce && wr && !soft_reset && addr == OFF_INIT_CHAN_LO;
    endsequence

    chk_bw_write_lands: assert property (
        @(posedge clk) disable iff (!rstn)
        s_bw_wr |=> init_bw_reg == $past(wdata[12:0]))
        else $error("initial bandwidth write did not land");

    chk_hi_write_lands: assert property (
        @(posedge clk) disable iff (!rstn)
        s_hi_wr |=> init_hi_reg == $past(wdata))
        else $error("initial channels high write did not land");

    chk_lo_write_lands: assert property (
        @(posedge clk) disable iff (!rstn)
        s_lo_wr |=> init_lo_reg == $past(wdata))
        else $error("initial channels low write did not land");

    chk_irq_needs_event: assert property (
        @(posedge clk) disable iff (!rstn)
        iso_receive_summary_irq |-> (rx_event != 4'h0 && b.mask != 4'h0))
        else $error("summary irq high with no event or no mask bit");

endmodule

// File: iso_rx_mask_and_bus_mgmt_init_regs_test.sv
/*
 * Self-checking testbench for the receive mask and bus management initial
 * value register slice: register reads and writes, masked events, summary
 * irq, and the copy of the initial values on global, host bus and 1394 bus reset.
 * Assumes the design top and package compiled before this file.
 */
`timescale 1ns/10ps
module iso_rx_mask_and_bus_mgmt_init_regs_test;
    import iso_bank_pkg::*;

    localparam int CYCLE_LIMIT = 2000;

    logic        clk;
    logic        rstn;
    logic        ce;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic [3:0]  rx_event;
    logic        soft_reset;
    logic        global_reset_input;
    logic        host_bus_reset_input;
    logic        bus_reset_1394;
    logic        iso_receive_summary_irq;
    logic [12:0] bandwidth_available;
    logic [31:0] channels_available_hi;
    logic [31:0] channels_available_lo;
    int          n_errors;
    int          checks;
    int          cycle_cnt;

    iso_rx_mask_and_bus_mgmt_init_regs dut_u (
        .clk                     (clk),
        .rstn                    (rstn),
        .ce                      (ce),
        .addr                    (addr),
        .wdata                   (wdata),
        .wr                      (wr),
        .rd                      (rd),
        .rdata                   (rdata),
        .rx_event                (rx_event),
        .soft_reset              (soft_reset),
        .global_reset_input      (global_reset_input),
        .host_bus_reset_input    (host_bus_reset_input),
        .bus_reset_1394          (bus_reset_1394),
        .iso_receive_summary_irq (iso_receive_summary_irq),
        .bandwidth_available     (bandwidth_available),
        .channels_available_hi   (channels_available_hi),
        .channels_available_lo   (channels_available_lo)
    );

    ////////////////////////////////////////////////////////////////////////////////

    initial clk = 1'b0;
    always #20 clk = ~clk;

    task automatic tally_and_finish();
        if (n_errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Cuts a hung run short
    always @(posedge clk) begin
        cycle_cnt = cycle_cnt + 1;
        if (cycle_cnt == CYCLE_LIMIT) begin
            n_errors = n_errors + 1;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic set_ev(input logic [3:0] v);
        @(posedge clk);
        rx_event <= v;
        #1;
    endtask

    task automatic chk_csr(input logic [31:0] bw, input logic [31:0] hi, input logic [31:0] lo);
        chk({19'h0, bandwidth_available}, bw);
        chk(channels_available_hi, hi);
        chk(channels_available_lo, lo);
    endtask

    ////////////////////////////////////////////////////////////////////////////////

    initial begin
        rstn = 1'b0;
        ce = 1'b1;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        wr = 1'b0;
        rd = 1'b0;
        rx_event = 4'h0;
        soft_reset = 1'b0;
        global_reset_input = 1'b0;
        host_bus_reset_input = 1'b0;
        bus_reset_1394 = 1'b0;
        n_errors = 0;
        checks = 0;
        cycle_cnt = 0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;

        // Reset values and an unmapped place
        rd_chk(OFF_RX_MASK_SET, 32'h0000_0000);
        rd_chk(OFF_INIT_BW, 32'h0000_1333);
        rd_chk(OFF_INIT_CHAN_HI, 32'hFFFF_FFFF);
        rd_chk(OFF_INIT_CHAN_LO, 32'hFFFF_FFFF);
        @(posedge clk);
        #1;
        chk(rdata, 32'h0000_0000);
        rd_chk(8'hC0, 32'h0000_0000);
        chk_csr(32'h0000_1333, 32'hFFFF_FFFF, 32'hFFFF_FFFF);

        // Set and clear addresses of the mask
        wr_reg(OFF_RX_MASK_SET, 32'hFFFF_FFFF);
        rd_chk(OFF_RX_MASK_SET, 32'h0000_000F);
        rd_chk(OFF_RX_MASK_CLEAR, 32'h0000_000F);
        wr_reg(OFF_RX_MASK_CLEAR, 32'h0000_0005);
        rd_chk(OFF_RX_MASK_SET, 32'h0000_000A);
        wr_reg(OFF_RX_MASK_SET, 32'h0000_0000);
        wr_reg(OFF_RX_MASK_CLEAR, 32'h0000_0000);
        rd_chk(OFF_RX_MASK_CLEAR, 32'h0000_000A);

        // One context enabled at a time
        for (int n = 0; n < 4; n++) begin
            wr_reg(OFF_RX_MASK_CLEAR, 32'h0000_000F);
            wr_reg(OFF_RX_MASK_SET, 32'h1 << n);
            set_ev(4'hF);
            chk({31'h0, iso_receive_summary_irq}, 32'h1);
            rd_chk(OFF_RX_EVENT_CLEAR, 32'h1 << n);
            set_ev(4'hF & ~(4'h1 << n));
            chk({31'h0, iso_receive_summary_irq}, 32'h0);
            rd_chk(OFF_RX_EVENT_CLEAR, 32'h0000_0000);
            set_ev(4'h1 << n);
            chk({31'h0, iso_receive_summary_irq}, 32'h1);
        end
        set_ev(4'h0);
        chk({31'h0, iso_receive_summary_irq}, 32'h0);

        // Initial value fields, then a 1394 bus reset copy
        wr_reg(OFF_INIT_BW, 32'hFFFF_FFFF);
        rd_chk(OFF_INIT_BW, 32'h0000_1FFF);
        wr_reg(OFF_INIT_CHAN_HI, 32'h1234_5678);
        wr_reg(OFF_INIT_CHAN_LO, 32'h9ABC_DEF0);
        chk_csr(32'h0000_1333, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
        @(posedge clk);
        bus_reset_1394 <= 1'b1;
        @(posedge clk);
        bus_reset_1394 <= 1'b0;
        #1;
        chk_csr(32'h0000_1FFF, 32'h1234_5678, 32'h9ABC_DEF0);
        rd_chk(OFF_INIT_BW, 32'h0000_1FFF);
        rd_chk(OFF_INIT_CHAN_HI, 32'h1234_5678);
        rd_chk(OFF_INIT_CHAN_LO, 32'h9ABC_DEF0);

        // Global and host bus reset pins, through their synchronisers
        for (int p = 0; p < 2; p++) begin
            wr_reg(OFF_INIT_BW, 32'h0000_0ABC + p);
            wr_reg(OFF_INIT_CHAN_HI, 32'hA5A5_0000 + p);
            wr_reg(OFF_INIT_CHAN_LO, 32'h0000_5A5A + p);
            @(posedge clk);
            if (p == 0) global_reset_input <= 1'b1;
            else host_bus_reset_input <= 1'b1;
            @(posedge clk);
            global_reset_input <= 1'b0;
            host_bus_reset_input <= 1'b0;
            repeat (4) @(posedge clk);
            #1;
            chk_csr(32'h0000_0ABC + p, 32'hA5A5_0000 + p, 32'h0000_5A5A + p);
        end

        // Software reset restores the fields only
        @(posedge clk);
        soft_reset <= 1'b1;
        @(posedge clk);
        soft_reset <= 1'b0;
        rd_chk(OFF_INIT_BW, 32'h0000_1333);
        rd_chk(OFF_INIT_CHAN_HI, 32'hFFFF_FFFF);
        rd_chk(OFF_INIT_CHAN_LO, 32'hFFFF_FFFF);
        rd_chk(OFF_RX_MASK_SET, 32'h0000_0008);
        chk_csr(32'h0000_0ABD, 32'hA5A5_0001, 32'h0000_5A5B);

        // Strobes ignored while the clock enable is low
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(OFF_RX_MASK_SET, 32'h0000_0007);
        ce <= 1'b1;
        rd_chk(OFF_RX_MASK_CLEAR, 32'h0000_0008);

        // Mid-run reset acts with the clock enable low
        wr_reg(OFF_RX_MASK_SET, 32'h0000_0003);
        wr_reg(OFF_INIT_BW, 32'h0000_0123);
        @(posedge clk);
        rstn <= 1'b0;
        ce <= 1'b0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        ce <= 1'b1;
        rd_chk(OFF_RX_MASK_SET, 32'h0000_0000);
        rd_chk(OFF_INIT_BW, 32'h0000_1333);
        chk_csr(32'h0000_1333, 32'hFFFF_FFFF, 32'hFFFF_FFFF);

        tally_and_finish();
    end
endmodule

// File: rx_mask_bank.sv
/*
 * Per-context receive mask with separate set and clear strobes.
 * Assumes set and clear come from the register decode on the same clock.
 */
`timescale 1ns/10ps
module rx_mask_bank
    import iso_bank_pkg::*;
(
    input  wire logic   clk,    // 25 MHz clock
    input  wire logic   rstn,   // Synchronous reset, active low
    input  wire logic   ce,     // Clock enable
    bank_if.mask_side   b       // Mask strobes and value
);
    logic [3:0] mask_reg;
    logic [3:0] mask_next;

    always_comb begin
        mask_next = (mask_reg | b.mask_set) & ~b.mask_clr;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            mask_reg <= RST_RX_MASK;
        end else if (ce) begin
            mask_reg <= mask_next;
        end
    end

    assign b.mask = mask_reg;
endmodule
